/* File: rtl/gcf_global_ctrl.sv */
// Global control fields of a three-port switch core, reached over APB.
// Assumes the frame and egress inputs come from core logic on clk_in
// and that the strap inputs are pins held stable around reset.
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
`include "gcf_defines.svh"

// Behaviour
// - With the legal size check on, tagged frames over 1522 and untagged frames over 1518 bytes are dropped.
// - With the check off and oversize support off, frames up to 1536 bytes inclusive are accepted.
// - Oversize support accepts frames up to 1916 bytes inclusive and overrides the legal size check.
// - Buffer reservation on sets aside 48 buffers per port for high priority frames, off reserves none.
// - The VLAN enable bit switches 802.1Q forwarding on or off and resets to zero.
// - With snooping on, every IGMP frame is also forwarded to the switch MII port.
// - The two-bit scheme picks strict priority or high/low ratios of 10/1, 5/1 or 2/1, resetting to strict.
// - With the mirror mode bit set, a frame is mirrored only when both source and destination match.
// - With the mirror mode bit clear, a frame is mirrored when either source or destination matches.
// - The MII duplex bit set runs the switch MII in half duplex, clear runs it in full duplex.
module gcf_global_ctrl #(
    parameter int ADDR_W = 12
) (
    input logic clk_in,
    input logic srst_in,
    input logic psel_in,
    input logic penable_in,
    input logic pwrite_in,
    input logic [ADDR_W-1:0] paddr_in,
    input logic [31:0] pwdata_in,
    input logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input logic strap_legal_max_in,
    input logic strap_no_coll_drop_in,
    input logic strap_mii_half_in,
    input logic strap_mii_flow_in,
    input logic strap_mii_10mbps_in,
    input logic frame_valid_in,
    input gcf_pkg::gcf_len_t frame_len_in,
    input logic frame_tagged_in,
    input logic frame_igmp_in,
    input logic mirror_src_match_in,
    input logic mirror_dst_match_in,
    output logic frame_done_out,
    output logic frame_drop_out,
    output logic frame_to_mii_out,
    output logic frame_mirror_out,
    output logic vlan_mode_out,
    output gcf_pkg::gcf_bufcnt_t hp_reserved_bufs_out,
    output logic mii_half_duplex_out,
    output logic mii_flow_ctrl_out,
    output logic mii_10mbps_out,
    input logic egress_hi_pending_in,
    input logic egress_lo_pending_in,
    input logic egress_take_in,
    output logic egress_pick_hi_out,
    output logic egress_pick_lo_out
);
    import gcf_pkg::*;

    // ----------------------------------------
    // State and decode signals
    // ----------------------------------------
    gcf_state_s st_reg;
    gcf_state_s st_next;

    logic [`GCF_STRAP_N-1:0] strap_pins;
    logic setup_phase;
    logic access_wr;
    logic addr_aligned;
    logic [7:0] addr_index;
    logic hit_frame_buf;
    logic hit_vlan_prio;
    logic hit_mii;
    logic hit_status;
    logic addr_hit;
    logic lane0_wr;
    logic [7:0] rd_mux;

    gcf_len_t size_limit;
    logic size_drop;
    logic mirror_hit;
    logic drop_event;
    logic status_clear;

    gcf_sched_if sched_bus ();

    assign strap_pins = {
        strap_mii_10mbps_in,
        strap_mii_flow_in,
        strap_mii_half_in,
        strap_no_coll_drop_in,
        strap_legal_max_in
    };

    // ----------------------------------------
    // APB address decode
    // ----------------------------------------
    // Upper address bits must be zero, so aliases never reach a register
    assign addr_index = paddr_in[9:2];
    assign addr_aligned = (paddr_in[1:0] == 2'b00) && (paddr_in[ADDR_W-1:10] == '0);
    assign hit_frame_buf = addr_aligned && (addr_index == `GCF_IDX_FRAME_BUF);
    assign hit_vlan_prio = addr_aligned && (addr_index == `GCF_IDX_VLAN_PRIO);
    assign hit_mii = addr_aligned && (addr_index == `GCF_IDX_MII);
    assign hit_status = addr_aligned && (addr_index == `GCF_IDX_STATUS);
    assign addr_hit = hit_frame_buf | hit_vlan_prio | hit_mii | hit_status;

    assign setup_phase = psel_in & ~penable_in;
    // No wait states, so every access phase completes at its first edge
    assign access_wr = psel_in & penable_in & pwrite_in & addr_hit;
    assign lane0_wr = access_wr & pstrb_in[0];

    always_comb begin
        rd_mux = 8'h00;
        if (hit_frame_buf) begin
            rd_mux = st_reg.frame_buf;
        end else if (hit_vlan_prio) begin
            rd_mux = st_reg.vlan_prio;
        end else if (hit_mii) begin
            rd_mux = st_reg.mii;
        end else if (hit_status) begin
            rd_mux = st_reg.drop_count;
        end
    end

    // ----------------------------------------
    // Frame size limit
    // ----------------------------------------
    always_comb begin
        if (st_reg.frame_buf[`GCF_B_OVERSIZE]) begin
            size_limit = `GCF_LEN_OVERSIZE;
        end else if (st_reg.frame_buf[`GCF_B_LEGAL_MAX]) begin
            if (frame_tagged_in) begin
                size_limit = `GCF_LEN_TAGGED;
            end else begin
                size_limit = `GCF_LEN_UNTAGGED;
            end
        end else begin
            size_limit = `GCF_LEN_DEFAULT;
        end
    end

    // Limits are inclusive: only a length above the limit drops
    assign size_drop = (frame_len_in > size_limit);

    // ----------------------------------------
    // Mirror match
    // ----------------------------------------
    always_comb begin
        if (st_reg.vlan_prio[`GCF_B_MIRROR_AND]) begin
            mirror_hit = mirror_src_match_in & mirror_dst_match_in;
        end else begin
            mirror_hit = mirror_src_match_in | mirror_dst_match_in;
        end
    end

    assign drop_event = frame_valid_in & size_drop;
    assign status_clear = access_wr & hit_status & pstrb_in[0];

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;

        // Synchroniser: the first stage feeds only the second
        st_next.strap_meta = strap_pins;
        st_next.strap_sync = st_reg.strap_meta;

        // Read data and error are fixed in setup and held through access
        if (setup_phase) begin
            st_next.rdata = pwrite_in ? 8'h00 : rd_mux;
            st_next.slverr = ~addr_hit;
        end

        // Register writes, reserved bits are stored as written
        if (lane0_wr && hit_frame_buf) begin
            st_next.frame_buf = pwdata_in[7:0];
        end
        if (lane0_wr && hit_vlan_prio) begin
            st_next.vlan_prio = pwdata_in[7:0];
        end
        if (lane0_wr && hit_mii) begin
            st_next.mii = pwdata_in[7:0];
        end

        // Drop counter saturates; a drop in the clearing cycle still counts
        if (status_clear) begin
            st_next.drop_count = drop_event ? 8'h01 : 8'h00;
        end else if (drop_event && (st_reg.drop_count != `GCF_CNT_MAX)) begin
            st_next.drop_count = st_reg.drop_count + 8'h01;
        end

        // One registered verdict per frame
        st_next.res_valid = frame_valid_in;
        if (frame_valid_in) begin
            st_next.res_drop = size_drop;
            st_next.res_to_mii = frame_igmp_in & st_reg.vlan_prio[`GCF_B_SNOOP_EN];
            st_next.res_mirror = mirror_hit;
        end

        if (srst_in) begin
            st_next.frame_buf = `GCF_FRAME_BUF_RST;
            st_next.frame_buf[`GCF_B_LEGAL_MAX] = st_reg.strap_sync[`GCF_STRAP_LEGAL];
            st_next.frame_buf[`GCF_B_NO_COLL_DROP] = st_reg.strap_sync[`GCF_STRAP_NO_COLL];
            st_next.vlan_prio = `GCF_VLAN_PRIO_RST;
            st_next.mii = `GCF_MII_RST;
            st_next.mii[`GCF_B_MII_HALF] = st_reg.strap_sync[`GCF_STRAP_HALF];
            st_next.mii[`GCF_B_MII_FLOW] = st_reg.strap_sync[`GCF_STRAP_FLOW];
            st_next.mii[`GCF_B_MII_10MBPS] = st_reg.strap_sync[`GCF_STRAP_10MBPS];
            st_next.drop_count = 8'h00;
            st_next.rdata = 8'h00;
            st_next.slverr = 1'b0;
            st_next.res_valid = 1'b0;
            st_next.res_drop = 1'b0;
            st_next.res_to_mii = 1'b0;
            st_next.res_mirror = 1'b0;
        end

        // Follows the register so it changes in the same cycle as the bit
        if (st_next.frame_buf[`GCF_B_HP_RESERVE]) begin
            st_next.hp_bufs = `GCF_HP_BUFS;
        end else begin
            st_next.hp_bufs = 6'h00;
        end
    end

    always_ff @(posedge clk_in) begin
        st_reg <= st_next;
    end

    // ----------------------------------------
    // Egress scheduler
    // ----------------------------------------
    assign sched_bus.mode = gcf_prio_mode_e'({st_reg.vlan_prio[`GCF_B_PRIO_HI], st_reg.vlan_prio[`GCF_B_PRIO_LO]});
    assign sched_bus.hi_pending = egress_hi_pending_in;
    assign sched_bus.lo_pending = egress_lo_pending_in;
    assign sched_bus.take = egress_take_in;

    gcf_egress_sched u_sched (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .sif(sched_bus.sched)
    );

    assign egress_pick_hi_out = sched_bus.pick_hi;
    assign egress_pick_lo_out = sched_bus.pick_lo;

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata_out = {24'h00_0000, st_reg.rdata};
    assign pready_out = 1'b1;
    assign pslverr_out = st_reg.slverr;

    assign frame_done_out = st_reg.res_valid;
    assign frame_drop_out = st_reg.res_drop;
    assign frame_to_mii_out = st_reg.res_to_mii;
    assign frame_mirror_out = st_reg.res_mirror;

    assign vlan_mode_out = st_reg.vlan_prio[`GCF_B_VLAN_EN];
    assign hp_reserved_bufs_out = st_reg.hp_bufs;
    assign mii_half_duplex_out = st_reg.mii[`GCF_B_MII_HALF];
    assign mii_flow_ctrl_out = st_reg.mii[`GCF_B_MII_FLOW];
    assign mii_10mbps_out = st_reg.mii[`GCF_B_MII_10MBPS];
endmodule : gcf_global_ctrl

/* File: rtl/gcf_defines.svh */
// Offsets, field positions, reset values and limits of the global control fields.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef GCF_DEFINES_SVH
`define GCF_DEFINES_SVH
// ----------------------------------------
// Register indexes, byte address is four times the index
// ----------------------------------------
`define GCF_IDX_FRAME_BUF 8'h04
`define GCF_IDX_VLAN_PRIO 8'h05
`define GCF_IDX_MII 8'h06
`define GCF_IDX_STATUS 8'h10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define GCF_B_OVERSIZE 2
`define GCF_B_LEGAL_MAX 1
`define GCF_B_HP_RESERVE 0
`define GCF_B_NO_COLL_DROP 3
`define GCF_B_VLAN_EN 7
`define GCF_B_SNOOP_EN 6
`define GCF_B_PRIO_HI 3
`define GCF_B_PRIO_LO 2
`define GCF_B_MIRROR_AND 0
`define GCF_B_MII_HALF 6
`define GCF_B_MII_FLOW 5
`define GCF_B_MII_10MBPS 4
// ----------------------------------------
// Reset values, strap bits are merged in at reset
// ----------------------------------------
`define GCF_FRAME_BUF_RST 8'hF1
`define GCF_VLAN_PRIO_RST 8'h00
`define GCF_MII_RST 8'h00
`define GCF_STRAP_N 5
`define GCF_STRAP_LEGAL 0
`define GCF_STRAP_NO_COLL 1
`define GCF_STRAP_HALF 2
`define GCF_STRAP_FLOW 3
`define GCF_STRAP_10MBPS 4
// ----------------------------------------
// Frame limits in bytes, buffer and ratio counts
// ----------------------------------------
`define GCF_LEN_TAGGED 11'h5F2
`define GCF_LEN_UNTAGGED 11'h5EE
`define GCF_LEN_DEFAULT 11'h600
`define GCF_LEN_OVERSIZE 11'h77C
`define GCF_HP_BUFS 6'h30
`define GCF_RATIO_10_1 4'hA
`define GCF_RATIO_5_1 4'h5
`define GCF_RATIO_2_1 4'h2
`define GCF_CNT_MAX 8'hFF
`endif

/* File: rtl/gcf_pkg.sv */
// Types shared by the global control block and its egress scheduler.
// Assumes the defines header sits in the include path.
`include "gcf_defines.svh"
package gcf_pkg;
    typedef logic [10:0] gcf_len_t;
    typedef logic [5:0] gcf_bufcnt_t;
    typedef enum logic [1:0] {
        GCF_PRIO_STRICT = 2'b00,
        GCF_PRIO_10_1 = 2'b01,
        GCF_PRIO_5_1 = 2'b10,
        GCF_PRIO_2_1 = 2'b11
    } gcf_prio_mode_e;
    typedef enum logic [1:0] {
        GCF_SCHED_HI_RUN = 2'b01,
        GCF_SCHED_LO_TURN = 2'b10
    } gcf_sched_state_e;
    typedef struct packed {
        gcf_sched_state_e state;
        logic [3:0] hi_count;
    } gcf_sched_s;
    typedef struct packed {
        logic [7:0] frame_buf;
        logic [7:0] vlan_prio;
        logic [7:0] mii;
        logic [7:0] drop_count;
        logic [7:0] rdata;
        logic slverr;
        logic [`GCF_STRAP_N-1:0] strap_meta;
        logic [`GCF_STRAP_N-1:0] strap_sync;
        logic res_valid;
        logic res_drop;
        logic res_to_mii;
        logic res_mirror;
        gcf_bufcnt_t hp_bufs;
    } gcf_state_s;
endpackage : gcf_pkg

/* File: rtl/gcf_sched_if.sv */
// Link between the control registers and the egress priority scheduler.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface gcf_sched_if;
    gcf_pkg::gcf_prio_mode_e mode;
    logic hi_pending;
    logic lo_pending;
    logic take;
    logic pick_hi;
    logic pick_lo;
    modport ctrl (output mode, output hi_pending, output lo_pending, output take, input pick_hi, input pick_lo);
    modport sched (input mode, input hi_pending, input lo_pending, input take, output pick_hi, output pick_lo);
endinterface : gcf_sched_if

/* File: rtl/gcf_egress_sched.sv */
// Egress priority scheduler: strict or weighted high/low selection.
// Assumes take pulses for one cycle when the port starts the picked frame.
`timescale 1ns/100ps
module gcf_egress_sched (
    input logic clk_in,
    input logic srst_in,
    gcf_sched_if.sched sif
);
    import gcf_pkg::*;

    gcf_sched_s st_reg;
    gcf_sched_s st_next;
    logic [3:0] ratio;
    logic owe_lo;
    logic [3:0] count_inc;

    // A low frame is owed only in LO_TURN; strict mode never enters it
    assign owe_lo = (st_reg.state == GCF_SCHED_LO_TURN);
    assign sif.pick_lo = sif.lo_pending & (owe_lo | ~sif.hi_pending);
    assign sif.pick_hi = sif.hi_pending & ~sif.pick_lo;
    assign count_inc = st_reg.hi_count + 4'h1;

    always_comb begin
        st_next = st_reg;
        ratio = 4'h0;
        unique case (sif.mode)
            GCF_PRIO_STRICT: ratio = 4'h0;
            GCF_PRIO_10_1: ratio = `GCF_RATIO_10_1;
            GCF_PRIO_5_1: ratio = `GCF_RATIO_5_1;
            GCF_PRIO_2_1: ratio = `GCF_RATIO_2_1;
        endcase
        unique case (st_reg.state)
            GCF_SCHED_HI_RUN: begin
                if (sif.take && sif.pick_lo) begin
                    st_next.hi_count = 4'h0;
                end else if (sif.take && sif.pick_hi && (ratio != 4'h0)) begin
                    // Compare with >= so a ratio lowered mid-run still hands over
                    if (count_inc >= ratio) begin
                        st_next.state = GCF_SCHED_LO_TURN;
                        st_next.hi_count = 4'h0;
                    end else begin
                        st_next.hi_count = count_inc;
                    end
                end
            end
            GCF_SCHED_LO_TURN: begin
                if (sif.take && sif.pick_lo) begin
                    st_next.state = GCF_SCHED_HI_RUN;
                end
            end
        endcase
        if (srst_in || (ratio == 4'h0)) begin
            st_next.state = GCF_SCHED_HI_RUN;
            st_next.hi_count = 4'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        st_reg <= st_next;
    end
endmodule : gcf_egress_sched

/* File: sim/gcf_global_ctrl_asserts.sv */
// Port-level checker for the global control block.
// Assumes it is bound into every gcf_global_ctrl instance.
`timescale 1ns/100ps
`include "gcf_defines.svh"
module gcf_global_ctrl_asserts (
    input logic clk_in,
    input logic srst_in,
    input logic psel_in,
    input logic penable_in,
    input logic pwrite_in,
    input logic frame_valid_in,
    input gcf_pkg::gcf_len_t frame_len_in,
    input logic frame_igmp_in,
    input logic mirror_src_match_in,
    input logic mirror_dst_match_in,
    input logic frame_done_out,
    input logic frame_drop_out,
    input logic frame_to_mii_out,
    input logic frame_mirror_out,
    input logic vlan_mode_out,
    input gcf_pkg::gcf_bufcnt_t hp_reserved_bufs_out,
    input logic mii_half_duplex_out,
    input logic egress_hi_pending_in,
    input logic egress_lo_pending_in,
    input logic egress_pick_hi_out,
    input logic egress_pick_lo_out
);
    import gcf_pkg::*;
    // ----------------------------------------
    // Relations
    // ----------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    a_done_pulse: assert property (1'b1 |=> frame_done_out == $past(frame_valid_in))
        else $error("frame_done_out not one cycle after request");
    a_short_kept: assert property (frame_valid_in && frame_len_in <= `GCF_LEN_UNTAGGED |=> !frame_drop_out)
        else $error("short frame dropped");
    a_huge_drop: assert property (frame_valid_in && frame_len_in > `GCF_LEN_OVERSIZE |=> frame_drop_out)
        else $error("frame above largest limit kept");
    a_snoop_only: assert property (frame_valid_in && !frame_igmp_in |=> !frame_to_mii_out)
        else $error("non-snooped frame sent to MII");
    a_mirror_both: assert property (frame_valid_in && mirror_src_match_in && mirror_dst_match_in
        |=> frame_mirror_out)
        else $error("full match not mirrored");
    a_mirror_none: assert property (frame_valid_in && !(mirror_src_match_in || mirror_dst_match_in)
        |=> !frame_mirror_out)
        else $error("unmatched frame mirrored");
    a_verdict_hold: assert property (!frame_done_out |-> $stable({frame_drop_out, frame_to_mii_out,
        frame_mirror_out}))
        else $error("verdict moved without done");
    a_hp_bufs: assert property (hp_reserved_bufs_out == `GCF_HP_BUFS || hp_reserved_bufs_out == 6'h00)
        else $error("reserved buffer count illegal");
    a_pick_one: assert property (!(egress_pick_hi_out && egress_pick_lo_out))
        else $error("both picks high");
    a_hi_alone: assert property (egress_hi_pending_in && !egress_lo_pending_in |-> egress_pick_hi_out)
        else $error("lone high frame not picked");
    // The last reset edge loads the strap levels, so it may move these too
    a_cfg_by_write: assert property ($changed({vlan_mode_out, mii_half_duplex_out})
        |-> $past(psel_in && penable_in && pwrite_in) || $past(srst_in))
        else $error("mode output moved without write");
    c_drop: cover property (frame_done_out && frame_drop_out);
    c_pick_lo: cover property (egress_pick_lo_out && egress_hi_pending_in);
    c_mirror: cover property (frame_done_out && frame_mirror_out);
endmodule : gcf_global_ctrl_asserts

bind gcf_global_ctrl gcf_global_ctrl_asserts gcf_global_ctrl_asserts_i (.clk_in, .srst_in, .psel_in, .penable_in,
    .pwrite_in, .frame_valid_in, .frame_len_in, .frame_igmp_in, .mirror_src_match_in, .mirror_dst_match_in,
    .frame_done_out, .frame_drop_out, .frame_to_mii_out, .frame_mirror_out, .vlan_mode_out, .hp_reserved_bufs_out,
    .mii_half_duplex_out, .egress_hi_pending_in, .egress_lo_pending_in, .egress_pick_hi_out, .egress_pick_lo_out);

/* File: sim/gcf_global_ctrl_tb_top.sv */
// Self-checking bench for the global control block.
// Assumes the design files and package compile first.
`timescale 1ns/100ps
`include "gcf_defines.svh"
module gcf_global_ctrl_tb_top;
    import gcf_pkg::*;
    logic clk_in = 1'b0, srst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0000_0000;
    logic [3:0] pstrb_in = 4'h0;
    logic [3:0] strb = 4'h1;
    logic strap_legal_max_in = 1'b1;
    logic [31:0] prdata_out, rd;
    logic pready_out, pslverr_out, rerr;
    logic frame_valid_in = 1'b0, frame_tagged_in = 1'b0, frame_igmp_in = 1'b0;
    logic mirror_src_match_in = 1'b0, mirror_dst_match_in = 1'b0;
    gcf_len_t frame_len_in = 11'h000;
    logic frame_done_out, frame_drop_out, frame_to_mii_out, frame_mirror_out, vlan_mode_out;
    gcf_bufcnt_t hp_reserved_bufs_out;
    logic mii_half_duplex_out, mii_flow_ctrl_out, mii_10mbps_out, egress_pick_hi_out, egress_pick_lo_out;
    logic egress_hi_pending_in = 1'b0, egress_lo_pending_in = 1'b0, egress_take_in = 1'b0;
    int err_count = 0;
    int tests_run = 0;
    // Straps fixed but the legal check, which t_strap flips across a mid-run reset
    gcf_global_ctrl #(.ADDR_W(12)) gcf_global_ctrl_i (.clk_in, .srst_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .strap_legal_max_in,
        .strap_no_coll_drop_in(1'b0), .strap_mii_half_in(1'b1), .strap_mii_flow_in(1'b0),
        .strap_mii_10mbps_in(1'b1), .frame_valid_in, .frame_len_in, .frame_tagged_in, .frame_igmp_in,
        .mirror_src_match_in, .mirror_dst_match_in, .frame_done_out, .frame_drop_out, .frame_to_mii_out,
        .frame_mirror_out, .vlan_mode_out, .hp_reserved_bufs_out, .mii_half_duplex_out, .mii_flow_ctrl_out,
        .mii_10mbps_out, .egress_hi_pending_in, .egress_lo_pending_in, .egress_take_in, .egress_pick_hi_out,
        .egress_pick_lo_out);
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] wd);
        int n;
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= {24'h00_0000, wd};
        pstrb_in <= strb;
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 8);
        if (pready_out !== 1'b1) begin
            err_count++;
            give_verdict();
        end
        rd = prdata_out;
        rerr = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        // Callers look at outputs that the access edge itself updates
        #1;
    endtask : apb
    // Qualifiers q = {tagged, igmp, src match, dst match}, exp = {drop, to_mii, mirror}
    task automatic frame(input gcf_len_t len, input logic [3:0] q, input logic [2:0] exp);
        @(posedge clk_in);
        frame_valid_in <= 1'b1;
        frame_len_in <= len;
        {frame_tagged_in, frame_igmp_in, mirror_src_match_in, mirror_dst_match_in} <= q;
        @(posedge clk_in);
        frame_valid_in <= 1'b0;
        #1;
        chk("frame_done", 32'h1, frame_done_out);
        chk("verdict", exp, {frame_drop_out, frame_to_mii_out, frame_mirror_out});
    endtask : frame
    task automatic take(input logic exp_lo);
        #1;
        chk("pick_lo", exp_lo, egress_pick_lo_out);
        chk("pick_hi", !exp_lo, egress_pick_hi_out);
        @(posedge clk_in);
        egress_take_in <= 1'b1;
        @(posedge clk_in);
        egress_take_in <= 1'b0;
    endtask : take
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        apb(1'b0, 12'h010, 8'h00);
        chk("frame_buf", 32'h0000_00F3, rd);
        apb(1'b0, 12'h014, 8'h00);
        chk("vlan_prio", 32'h0000_0000, rd);
        apb(1'b0, 12'h018, 8'h00);
        chk("mii", 32'h0000_0050, rd);
        chk("hp_bufs", `GCF_HP_BUFS, hp_reserved_bufs_out);
        chk("half", 32'h1, mii_half_duplex_out);
        chk("flow", 32'h0, mii_flow_ctrl_out);
        chk("10 Mbps", 32'h1, mii_10mbps_out);
    endtask : t_reset
    task automatic t_refuse();
        apb(1'b0, 12'h020, 8'h00);
        chk("unmapped err", 32'h1, rerr);
        chk("unmapped data", 32'h0, rd);
        strb = 4'h0;
        apb(1'b1, 12'h014, 8'h80);
        strb = 4'h1;
        chk("no strobe err", 32'h0, rerr);
        chk("no strobe kept", 32'h0, vlan_mode_out);
        apb(1'b1, 12'h015, 8'h80);
        chk("misaligned err", 32'h1, rerr);
        chk("vlan kept", 32'h0, vlan_mode_out);
    endtask : t_refuse
    task automatic t_size();
        apb(1'b1, 12'h010, 8'hF3);
        frame(11'h5F2, 4'h8, 3'b000);
        frame(11'h5F3, 4'h8, 3'b100);
        frame(11'h5EE, 4'h0, 3'b000);
        frame(11'h5EF, 4'h0, 3'b100);
        apb(1'b1, 12'h010, 8'hF1);
        frame(11'h600, 4'h0, 3'b000);
        frame(11'h601, 4'h8, 3'b100);
        apb(1'b1, 12'h010, 8'hF7);
        frame(11'h77C, 4'h8, 3'b000);
        frame(11'h640, 4'h0, 3'b000);
        frame(11'h77D, 4'h0, 3'b100);
        apb(1'b1, 12'h010, 8'hF2);
        chk("hp_bufs off", 32'h0, hp_reserved_bufs_out);
        apb(1'b1, 12'h010, 8'hF3);
        chk("hp_bufs on", `GCF_HP_BUFS, hp_reserved_bufs_out);
        apb(1'b0, 12'h040, 8'h00);
        chk("drops", 32'h0000_0004, rd);
    endtask : t_size
    task automatic t_fwd();
        apb(1'b1, 12'h014, 8'h80);
        chk("vlan on", 32'h1, vlan_mode_out);
        apb(1'b1, 12'h014, 8'h40);
        chk("vlan off", 32'h0, vlan_mode_out);
        frame(11'h040, 4'h4, 3'b010);
        frame(11'h040, 4'h0, 3'b000);
        apb(1'b1, 12'h014, 8'h01);
        frame(11'h040, 4'h2, 3'b000);
        frame(11'h040, 4'h3, 3'b001);
        apb(1'b1, 12'h014, 8'h00);
        frame(11'h040, 4'h2, 3'b001);
        frame(11'h040, 4'h5, 3'b001);
    endtask : t_fwd
    task automatic t_mii();
        apb(1'b1, 12'h018, 8'h00);
        chk("full duplex", 32'h0, mii_half_duplex_out);
        chk("100 Mbps", 32'h0, mii_10mbps_out);
        apb(1'b1, 12'h018, 8'h40);
        chk("half duplex", 32'h1, mii_half_duplex_out);
    endtask : t_mii
    task automatic t_sched();
        int r[4] = '{0, `GCF_RATIO_10_1, `GCF_RATIO_5_1, `GCF_RATIO_2_1};
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 12'h014, {4'h0, m[1:0], 2'b00});
            @(posedge clk_in);
            egress_hi_pending_in <= 1'b0;
            egress_lo_pending_in <= 1'b1;
            take(1'b1);
            @(posedge clk_in);
            egress_hi_pending_in <= 1'b1;
            for (int k = 0; k < 12; k++) begin
                take(r[m] != 0 && k % (r[m] + 1) == r[m]);
            end
        end
    endtask : t_sched
    task automatic t_strap();
        @(posedge clk_in);
        strap_legal_max_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        srst_in <= 1'b0;
        apb(1'b0, 12'h010, 8'h00);
        chk("strap legal off", 32'h0000_00F1, rd);
        apb(1'b0, 12'h014, 8'h00);
        chk("vlan_prio again", 32'h0000_0000, rd);
        frame(11'h5F3, 4'h8, 3'b000);
    endtask : t_strap
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    // Three reset edges let the synchronised straps reach the registers
    initial begin
        repeat (3) @(posedge clk_in);
        srst_in <= 1'b0;
        t_reset();
        t_refuse();
        t_size();
        t_fwd();
        t_mii();
        t_sched();
        t_strap();
        give_verdict();
    end
endmodule : gcf_global_ctrl_tb_top
